//--- core/ccd_pkg.sv
/*
 * Package of the condition-code datapath: register offsets, condition
 * code field positions, operation codes, access sizes and saturation
 * limits.
 * Assumes a 32-bit APB register bus with one aligned word per register.
 */
package ccd_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CCR = 8'h00;
    localparam logic [7:0] OFS_ACC_D = 8'h04;
    localparam logic [7:0] OFS_ACC_E = 8'h08;
    localparam logic [7:0] OFS_IDX_X = 8'h0C;
    localparam logic [7:0] OFS_IDX_Y = 8'h10;
    localparam logic [7:0] OFS_IDX_Z = 8'h14;
    localparam logic [7:0] OFS_OPND = 8'h18;
    localparam logic [7:0] OFS_CMD = 8'h1C;
    localparam logic [7:0] OFS_MAC_HI = 8'h20;
    localparam logic [7:0] OFS_MAC_LO = 8'h24;
    localparam logic [7:0] OFS_PC = 8'h28;
    localparam logic [7:0] OFS_FETCH = 8'h2C;
    localparam logic [7:0] OFS_DADDR = 8'h30;
    localparam logic [7:0] OFS_LDATA = 8'h34;
    localparam logic [7:0] OFS_STATUS = 8'h38;

    // ------------------------------------------------------------------
    // Condition code bit positions and reset value
    // ------------------------------------------------------------------
    localparam int CC_S = 15;
    localparam int CC_MV = 14;
    localparam int CC_H = 13;
    localparam int CC_EV = 12;
    localparam int CC_N = 11;
    localparam int CC_Z = 10;
    localparam int CC_V = 9;
    localparam int CC_C = 8;
    localparam int CC_IP_LO = 5;
    localparam int CC_SM = 4;
    localparam logic [15:0] CCR_RESET = 16'h00E0;

    // ------------------------------------------------------------------
    // Operation codes in command bits [3:0], access size in bits [5:4]
    // ------------------------------------------------------------------
    localparam logic [3:0] OP_ADDA = 4'h0;
    localparam logic [3:0] OP_ADDB = 4'h1;
    localparam logic [3:0] OP_ADDD = 4'h2;
    localparam logic [3:0] OP_ADCD = 4'h3;
    localparam logic [3:0] OP_SUBD = 4'h4;
    localparam logic [3:0] OP_SBCD = 4'h5;
    localparam logic [3:0] OP_ASLD = 4'h6;
    localparam logic [3:0] OP_RORD = 4'h7;
    localparam logic [3:0] OP_ANDD = 4'h8;
    localparam logic [3:0] OP_MAC = 4'h9;
    localparam logic [3:0] OP_TRANSFER_MAC_TO_E_SATURATED = 4'hA;
    localparam logic [3:0] OP_TRANSFER_ROUNDED_MAC_TO_E = 4'hB;
    localparam logic [3:0] OP_HALT = 4'hC;
    localparam logic [3:0] OP_LOAD = 4'hD;
    localparam logic [3:0] OP_STORE = 4'hE;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // ------------------------------------------------------------------
    // Saturation limits and access sequencer states
    // ------------------------------------------------------------------
    localparam logic [15:0] SAT_POS = 16'h7FFF;
    localparam logic [15:0] SAT_NEG = 16'h8000;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_ISSUE = 2'b01,
        ACC_WAIT = 2'b11
    } ccd_acc_t;

endpackage

//--- core/ccd_core.sv
/*
 * Condition-code datapath of a 16-bit core: flag generation, MAC with
 * overflow flags and saturation, interrupt level masking, low-power halt,
 * banked 20-bit addressing and byte, word and longword memory access.
 * Assumes an APB master on pclk, a memory whose read data stands while
 * mem_req is high, and an interrupt level from another clock domain.
 */
// The register addresses and the APB register port are this design's own decisions.
// Functional notes
// - Stop bit clear: halt stops the clock; set: halt does nothing.
// - Accumulator overflow flag sets when MAC result overflows into bit 35.
// - Half carry sets on carry out of bit 3 of A or B.
// - Extension overflow flag sets when MAC result overflows into bit 31.
// - Negative flag follows the result's most significant bit.
// - Zero flag sets when every result bit is zero.
// - Overflow flag sets on two's complement overflow.
// - Carry flag takes carry or borrow; shifts and rotates use it.
// - Three-bit interrupt level mask, 0 to 7, masks requests at or below it; level 7 is never masked.
// - Saturating transfers give extreme values when a MAC overflow flag is set.
// - Program bank field joined with program counter gives 20-bit address.
// - MAC multiplies signed 16-bit fractions into a 36-bit accumulator.
// - Separate one megabyte data and program spaces with 20-bit addresses.
// - Effective address is a 16-bit page address plus 4-bit extension.
// - Bytes at any address; a word sits at its lower byte address.
// - Instruction fetch addresses are always word aligned.
// - Misaligned words are done as two successive byte operations.
// - Two 16-bit accumulators and three 16-bit index registers.
// - Loads and stores of 8, 16 and 32 bits; signed fractional MAC.
module ccd_core
    import ccd_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Data memory port.
    output logic mem_req,
    output logic mem_we,
    output logic mem_word,
    output logic [19:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    // Interrupt level in and core control out.
    input wire logic [2:0] irq_level,
    output logic irq_take,
    output logic clock_stop
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
        logic [15:0] ccr;
        logic [15:0] d;
        logic [15:0] e;
        logic [15:0] ix;
        logic [15:0] iy;
        logic [15:0] iz;
        logic [15:0] opnd;
        logic [15:0] pc;
        logic [35:0] am;
        logic sat_sign;
        logic [19:0] daddr;
        logic [31:0] ldata;
        ccd_acc_t acc;
        logic acc_wr;
        logic [2:0] remain;
        logic req;
        logic we;
        logic word;
        logic [19:0] maddr;
        logic [15:0] wdata;
        logic halt;
        logic [2:0] irq_s1;
        logic [2:0] irq_s2;
        logic take;
    } ccd_state_t;

    ccd_state_t st_r;
    ccd_state_t st_nxt;

    // 8-bit add returning half carry, carry, overflow and sum.
    function automatic logic [10:0] add8(input logic [7:0] x,
                                         input logic [7:0] y);
        logic [4:0] lo;
        logic [8:0] s;
        lo = {1'b0, x[3:0]} + {1'b0, y[3:0]};
        s = {1'b0, x} + {1'b0, y};
        return {lo[4], s[8], (x[7] == y[7]) && (s[7] != x[7]), s[7:0]};
    endfunction

    // 16-bit add with carry in returning carry, overflow and sum.
    function automatic logic [17:0] add16(input logic [15:0] x,
                                          input logic [15:0] y,
                                          input logic cin);
        logic [16:0] s;
        s = {1'b0, x} + {1'b0, y} + {16'h0000, cin};
        return {s[16], (x[15] == y[15]) && (s[15] != x[15]), s[15:0]};
    endfunction

    // Saturating transfer of the upper accumulator word.
    function automatic logic [15:0] sat16(input logic [15:0] v,
                                          input logic [15:0] cc,
                                          input logic sgn);
        if (cc[CC_SM] && (cc[CC_EV] || cc[CC_MV])) begin
            return sgn ? SAT_NEG : SAT_POS;
        end
        return v;
    endfunction

    logic wr_en;
    logic rd_en;
    logic [10:0] r8;
    logic [17:0] r16;
    logic [31:0] prod;
    logic [36:0] sum37;
    logic [15:0] res;
    logic [3:0] op;
    logic [1:0] sz;
    logic go;
    logic use_word;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        r8 = 11'h000;
        r16 = 18'h00000;
        res = 16'h0000;
        prod = 32'h00000000;
        sum37 = 37'h0000000000;
        op = pwdata[3:0];
        sz = pwdata[5:4];
        use_word = 1'b0;
        // Setup cycle answers in the next cycle; access edge commits.
        rd_en = psel && !penable;
        wr_en = psel && penable && pwrite && st_r.ready;
        go = wr_en && (paddr == OFS_CMD) && !st_r.halt
            && (st_r.acc == ACC_IDLE);
        st_nxt.ready = rd_en;
        st_nxt.req = 1'b0;

        // Read data and error answer, prepared in the setup cycle.
        if (rd_en) begin
            st_nxt.slverr = 1'b0;
            st_nxt.rdata = 32'h00000000;
            case (paddr)
                OFS_CCR: st_nxt.rdata[15:0] = st_r.ccr;
                OFS_ACC_D: st_nxt.rdata[15:0] = st_r.d;
                OFS_ACC_E: st_nxt.rdata[15:0] = st_r.e;
                OFS_IDX_X: st_nxt.rdata[15:0] = st_r.ix;
                OFS_IDX_Y: st_nxt.rdata[15:0] = st_r.iy;
                OFS_IDX_Z: st_nxt.rdata[15:0] = st_r.iz;
                OFS_OPND: st_nxt.rdata[15:0] = st_r.opnd;
                OFS_CMD: st_nxt.slverr = pwrite
                    && (st_r.halt || st_r.acc != ACC_IDLE);
                OFS_MAC_HI: st_nxt.rdata[19:0] = st_r.am[35:16];
                OFS_MAC_LO: st_nxt.rdata[15:0] = st_r.am[15:0];
                OFS_PC: st_nxt.rdata[15:0] = st_r.pc;
                // Fetch address: bank field over the even program counter.
                OFS_FETCH: st_nxt.rdata[19:0] =
                    {st_r.ccr[3:0], st_r.pc[15:1], 1'b0};
                OFS_DADDR: st_nxt.rdata[19:0] = st_r.daddr;
                OFS_LDATA: st_nxt.rdata = st_r.ldata;
                OFS_STATUS: st_nxt.rdata[2:0] =
                    {st_r.take, st_r.acc != ACC_IDLE, st_r.halt};
                default: st_nxt.slverr = 1'b1;
            endcase
        end

        // Plain register writes.
        if (wr_en) begin
            case (paddr)
                OFS_CCR: st_nxt.ccr = pwdata[15:0];
                OFS_ACC_D: st_nxt.d = pwdata[15:0];
                OFS_ACC_E: st_nxt.e = pwdata[15:0];
                OFS_IDX_X: st_nxt.ix = pwdata[15:0];
                OFS_IDX_Y: st_nxt.iy = pwdata[15:0];
                OFS_IDX_Z: st_nxt.iz = pwdata[15:0];
                OFS_OPND: st_nxt.opnd = pwdata[15:0];
                OFS_PC: st_nxt.pc = pwdata[15:0];
                OFS_DADDR: st_nxt.daddr = pwdata[19:0];
                OFS_LDATA: st_nxt.ldata = pwdata;
                default: ;
            endcase
        end

        // Operations; flags not named in a branch keep their value.
        if (go) begin
            case (op)
                OP_ADDA, OP_ADDB: begin
                    r8 = add8(op == OP_ADDA ? st_r.d[15:8] : st_r.d[7:0],
                              st_r.opnd[7:0]);
                    if (op == OP_ADDA) begin
                        st_nxt.d[15:8] = r8[7:0];
                    end else begin
                        st_nxt.d[7:0] = r8[7:0];
                    end
                    st_nxt.ccr[CC_H] = r8[10];
                    st_nxt.ccr[CC_C] = r8[9];
                    st_nxt.ccr[CC_V] = r8[8];
                    st_nxt.ccr[CC_N] = r8[7];
                    st_nxt.ccr[CC_Z] = (r8[7:0] == 8'h00);
                end
                OP_ADDD, OP_ADCD, OP_SUBD, OP_SBCD: begin
                    // Subtract adds the inverse; carry out low is a borrow.
                    if (op == OP_ADDD || op == OP_ADCD) begin
                        r16 = add16(st_r.d, st_r.opnd,
                                    op == OP_ADCD && st_r.ccr[CC_C]);
                        st_nxt.ccr[CC_C] = r16[17];
                    end else begin
                        r16 = add16(st_r.d, ~st_r.opnd,
                                    !(op == OP_SBCD && st_r.ccr[CC_C]));
                        st_nxt.ccr[CC_C] = !r16[17];
                    end
                    st_nxt.d = r16[15:0];
                    st_nxt.ccr[CC_V] = r16[16];
                    st_nxt.ccr[CC_N] = r16[15];
                    st_nxt.ccr[CC_Z] = (r16[15:0] == 16'h0000);
                end
                OP_ASLD, OP_RORD, OP_ANDD: begin
                    // Shifts pass through carry so words chain.
                    if (op == OP_ASLD) begin
                        res = {st_r.d[14:0], 1'b0};
                        st_nxt.ccr[CC_C] = st_r.d[15];
                        st_nxt.ccr[CC_V] = st_r.d[15] ^ st_r.d[14];
                    end else if (op == OP_RORD) begin
                        res = {st_r.ccr[CC_C], st_r.d[15:1]};
                        st_nxt.ccr[CC_C] = st_r.d[0];
                        st_nxt.ccr[CC_V] = st_r.d[0] ^ st_r.ccr[CC_C];
                    end else begin
                        res = st_r.d & st_r.opnd;
                        st_nxt.ccr[CC_V] = 1'b0;
                    end
                    st_nxt.d = res;
                    st_nxt.ccr[CC_N] = res[15];
                    st_nxt.ccr[CC_Z] = (res == 16'h0000);
                end
                OP_MAC: begin
                    // Fractional product is shifted left once, then added.
                    prod = $signed(st_r.e) * $signed(st_r.opnd);
                    sum37 = {st_r.am[35], st_r.am}
                        + {{5{prod[30]}}, prod[30:0], 1'b0};
                    st_nxt.am = sum37[35:0];
                    if (sum37[36] != sum37[35]) begin
                        st_nxt.ccr[CC_MV] = 1'b1;
                    end
                    if (sum37[35:31] != {5{sum37[31]}}) begin
                        st_nxt.ccr[CC_EV] = 1'b1;
                    end
                    if ((sum37[36] != sum37[35])
                        || (sum37[35:31] != {5{sum37[31]}})) begin
                        st_nxt.sat_sign = sum37[36];
                    end
                end
                OP_TRANSFER_MAC_TO_E_SATURATED, OP_TRANSFER_ROUNDED_MAC_TO_E: begin
                    res = st_r.am[31:16];
                    if (op == OP_TRANSFER_ROUNDED_MAC_TO_E) begin
                        res = st_r.am[31:16] + {15'h0000, st_r.am[15]};
                    end
                    res = sat16(res, st_r.ccr, st_r.sat_sign);
                    st_nxt.e = res;
                    st_nxt.ccr[CC_N] = res[15];
                    st_nxt.ccr[CC_Z] = (res == 16'h0000);
                end
                OP_HALT: begin
                    st_nxt.halt = !st_r.ccr[CC_S];
                end
                OP_LOAD, OP_STORE: begin
                    // Store data is moved to the top so bytes leave first.
                    st_nxt.acc = ACC_ISSUE;
                    st_nxt.acc_wr = (op == OP_STORE);
                    case (sz)
                        SZ_BYTE: begin
                            st_nxt.remain = 3'd1;
                            st_nxt.ldata = {st_r.ldata[7:0], 24'h000000};
                        end
                        SZ_WORD: begin
                            st_nxt.remain = 3'd2;
                            st_nxt.ldata = {st_r.ldata[15:0], 16'h0000};
                        end
                        default: st_nxt.remain = 3'd4;
                    endcase
                    if (op == OP_LOAD) begin
                        st_nxt.ldata = 32'h00000000;
                    end
                    st_nxt.maddr = st_r.daddr;
                end
                default: ;
            endcase
        end

        // Access sequencer: one memory operation every two cycles.
        case (st_r.acc)
            ACC_IDLE: ;
            ACC_ISSUE: begin
                use_word = (st_r.remain >= 3'd2) && !st_r.maddr[0];
                st_nxt.req = 1'b1;
                st_nxt.we = st_r.acc_wr;
                st_nxt.word = use_word;
                if (use_word) begin
                    st_nxt.wdata = st_r.ldata[31:16];
                end else begin
                    st_nxt.wdata = {8'h00, st_r.ldata[31:24]};
                end
                st_nxt.acc = ACC_WAIT;
            end
            ACC_WAIT: begin
                // Data is shifted in low; the 20-bit add crosses banks.
                if (st_r.word) begin
                    st_nxt.ldata = st_r.acc_wr ? {st_r.ldata[15:0], 16'h0000}
                        : {st_r.ldata[15:0], mem_rdata};
                    st_nxt.remain = st_r.remain - 3'd2;
                    st_nxt.maddr = st_r.maddr + 20'h00002;
                end else begin
                    st_nxt.ldata = st_r.acc_wr ? {st_r.ldata[23:0], 8'h00}
                        : {st_r.ldata[23:0], mem_rdata[7:0]};
                    st_nxt.remain = st_r.remain - 3'd1;
                    st_nxt.maddr = st_r.maddr + 20'h00001;
                end
                st_nxt.acc = (st_nxt.remain == 3'd0) ? ACC_IDLE : ACC_ISSUE;
            end
            default: st_nxt.acc = ACC_IDLE;
        endcase

        // Interrupt level: two-stage synchroniser, then the mask test.
        st_nxt.irq_s1 = irq_level;
        st_nxt.irq_s2 = st_r.irq_s1;
        st_nxt.take = (st_r.irq_s2 == 3'd7)
            || (st_r.irq_s2 > st_r.ccr[CC_IP_LO +: 3]);
        // A taken interrupt restarts the stopped clock.
        if (st_r.halt && st_r.take) begin
            st_nxt.halt = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.ccr <= CCR_RESET;
            st_r.acc <= ACC_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.slverr;
    assign mem_req = st_r.req;
    assign mem_we = st_r.we;
    assign mem_word = st_r.word;
    assign mem_addr = st_r.maddr;
    assign mem_wdata = st_r.wdata;
    assign irq_take = st_r.take;
    assign clock_stop = st_r.halt;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic cmd_w;
    assign cmd_w = psel && penable && pwrite && pready && paddr == OFS_CMD
        && !clock_stop && st_r.acc == ACC_IDLE;

    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");
    halt_stops_a: assert property (
        cmd_w && pwdata[3:0] == OP_HALT && !st_r.ccr[CC_S] |=> clock_stop)
        else $error("halt with stop bit clear did not stop clock");
    halt_nop_a: assert property (
        cmd_w && pwdata[3:0] == OP_HALT && st_r.ccr[CC_S]
        |=> clock_stop == $past(clock_stop))
        else $error("halt with stop bit set changed clock state");
    zero_flag_a: assert property (
        cmd_w && pwdata[3:0] == OP_ADDD
        |=> st_r.ccr[CC_Z] == (st_r.d == 16'h0000))
        else $error("zero flag does not match sum");
    neg_flag_a: assert property (
        cmd_w && pwdata[3:0] == OP_SUBD |=> st_r.ccr[CC_N] == st_r.d[15])
        else $error("negative flag does not match difference");
    and_keeps_c_a: assert property (
        cmd_w && pwdata[3:0] == OP_ANDD
        |=> st_r.ccr[CC_C] == $past(st_r.ccr[CC_C]))
        else $error("logic operation changed carry");
    mv_sticky_a: assert property (
        st_r.ccr[CC_MV] && !(pready && pwrite && paddr == OFS_CCR)
        |=> st_r.ccr[CC_MV])
        else $error("accumulator overflow flag lost");
    sat_value_a: assert property (
        cmd_w && pwdata[3:0] == OP_TRANSFER_MAC_TO_E_SATURATED && st_r.ccr[CC_SM]
        && st_r.ccr[CC_EV]
        |=> st_r.e == SAT_POS || st_r.e == SAT_NEG)
        else $error("saturating transfer gave unsaturated value");
    word_aligned_a: assert property (
        mem_req && mem_word |-> !mem_addr[0])
        else $error("word operation at odd address");
    fetch_even_a: assert property (
        $rose(pready) && $past(paddr) == OFS_FETCH |-> !prdata[0])
        else $error("fetch address not word aligned");
    irq_mask_a: assert property (
        st_r.irq_s2 == 3'd0 |=> !irq_take)
        else $error("interrupt taken with no request");
    op_spacing_a: assert property (
        mem_req |=> !mem_req ##1 1'b1)
        else $error("memory operations issued back to back");

endmodule

//--- verif/ccd_mem_model.sv
/*
 * Data memory beside the datapath: 256 bytes, big-endian words.
 * Assumes one request per pulse of mem_req and no wait states.
 */
module ccd_mem_model (
    input wire logic pclk,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_word,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [256];
    logic [7:0] a;
    logic [15:0] rd;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    end
    // Read data stands while the request does, since the core takes it at
    // the edge that ends the request; otherwise the bus shows the inverse.
    assign a = mem_addr[7:0];
    assign rd = mem_word ? {mem[a], mem[a + 8'h01]} : {8'h00, mem[a]};
    assign mem_rdata = (mem_req && !mem_we) ? rd : ~rd;
    // Writes land at the edge that ends the request.
    always @(posedge pclk) begin
        if (mem_req && mem_we && mem_word) begin
            mem[a] <= mem_wdata[15:8];
            mem[a + 8'h01] <= mem_wdata[7:0];
        end else if (mem_req && mem_we) begin
            mem[a] <= mem_wdata[7:0];
        end
    end
endmodule

//--- verif/tb.sv
/*
 * Self-checking bench: APB accesses drive operations and read results.
 * Assumes the core answers every APB transfer and a memory model.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ccd_pkg::*;
    logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, mem_req, mem_we, mem_word, irq_take, clock_stop, e;
    logic [19:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata;
    logic [2:0] irq_level = 3'h0;
    int errors = 0, checks_done = 0;
    ccd_core u_ccd_core (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .irq_level(irq_level), .irq_take(irq_take), .clock_stop(clock_stop));
    ccd_mem_model u_ccd_mem_model (.pclk(pclk), .mem_req(mem_req),
        .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    // One APB transfer, entered just after a rising edge; an idle cycle
    // follows so that no strobe is written twice in one time step.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] s, x);
        checks_done++;
        if (s !== x) begin
            errors++;
            $display("mismatch %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x, string nm);
        apb(0, a, 32'h0); chk(nm, r, x);
    endtask
    task automatic cmd(input logic [1:0] sz, input logic [3:0] op);
        apb(1, OFS_CMD, {26'h0, sz, op});
    endtask
    // Runs one operation from a known state and checks D and the flags;
    // the flag byte sits above a fixed mask-7 low byte.
    task automatic op_chk(input logic [7:0] cc, input logic [15:0] d, o,
                          input logic [3:0] op, input logic [15:0] dx,
                          input logic [7:0] ccx);
        apb(1, OFS_CCR, {16'h0, cc, 8'hE0}); apb(1, OFS_ACC_D, {16'h0, d});
        apb(1, OFS_OPND, {16'h0, o}); cmd(SZ_BYTE, op);
        rc(OFS_ACC_D, {16'h0, dx}, "acc_d");
        rc(OFS_CCR, {16'h0, ccx, 8'hE0}, "ccr");
    endtask
    task automatic print_verdict();
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(25 * 20000); errors++; print_verdict();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1; @(posedge pclk);
        rc(OFS_CCR, 32'hE0, "ccr_rst");
        op_chk(8'h00, 16'h0F00, 16'h1, OP_ADDA, 16'h1000, 8'h20);
        op_chk(8'h00, 16'h00FF, 16'h1, OP_ADDB, 16'h0000, 8'h25);
        op_chk(8'h00, 16'h5, 16'h5, OP_SUBD, 16'h0, 8'h04);
        op_chk(8'h00, 16'h7FFF, 16'h1, OP_ADDD, 16'h8000, 8'h0A);
        op_chk(8'h00, 16'h0, 16'h1, OP_SUBD, 16'hFFFF, 8'h09);
        op_chk(8'h01, 16'h1, 16'h1, OP_ADCD, 16'h3, 8'h00);
        op_chk(8'h01, 16'h5, 16'h2, OP_SBCD, 16'h2, 8'h00);
        op_chk(8'h00, 16'hC001, 16'h0, OP_ASLD, 16'h8002, 8'h09);
        op_chk(8'h01, 16'h2, 16'h0, OP_RORD, 16'h8001, 8'h0A);
        op_chk(8'h21, 16'hFF00, 16'hF0F, OP_ANDD, 16'h0F00, 8'h21);
        // Full-scale products push the sum past bit 31, later past bit 35.
        apb(1, OFS_CCR, 32'hF0); apb(1, OFS_ACC_E, 32'h7FFF);
        apb(1, OFS_OPND, 32'h7FFF); cmd(SZ_BYTE, OP_MAC); cmd(SZ_BYTE, OP_MAC);
        rc(OFS_MAC_HI, 32'h0FFFC, "mac_hi");
        rc(OFS_MAC_LO, 32'h4, "mac_lo");
        cmd(SZ_BYTE, OP_TRANSFER_MAC_TO_E_SATURATED); rc(OFS_ACC_E, 32'h7FFF, "sat");
        rc(OFS_CCR, 32'h10F0, "ev");
        repeat (15) cmd(SZ_BYTE, OP_MAC);
        rc(OFS_MAC_HI, 32'h87FDE, "mac_ovf");
        rc(OFS_CCR, 32'h50F0, "mv");
        cmd(SZ_BYTE, OP_TRANSFER_ROUNDED_MAC_TO_E);
        rc(OFS_ACC_E, 32'h7FFF, "transfer_rounded_mac_to_e_sat");
        apb(1, OFS_CCR, 32'hE0); cmd(SZ_BYTE, OP_TRANSFER_ROUNDED_MAC_TO_E);
        rc(OFS_ACC_E, 32'h7FDE, "transfer_rounded_mac_to_e");
        apb(1, OFS_CCR, 32'hE5); apb(1, OFS_PC, 32'h1235);
        rc(OFS_FETCH, 32'h51234, "fetch");
        apb(1, OFS_DADDR, 32'h11); cmd(SZ_WORD, OP_LOAD);
        repeat (10) @(posedge pclk);
        rc(OFS_LDATA, 32'h4B48, "ld_odd");
        apb(1, OFS_DADDR, 32'h20); apb(1, OFS_LDATA, 32'h11223344);
        cmd(SZ_LONG, OP_STORE); repeat (10) @(posedge pclk);
        apb(1, OFS_DADDR, 32'h23); apb(1, OFS_LDATA, 32'hAB);
        cmd(SZ_BYTE, OP_STORE); repeat (10) @(posedge pclk);
        apb(1, OFS_DADDR, 32'h20); cmd(SZ_LONG, OP_LOAD);
        // A command while the access still runs is refused.
        cmd(SZ_BYTE, OP_HALT); chk("busy", {31'h0, e}, 32'h1);
        repeat (10) @(posedge pclk);
        rc(OFS_LDATA, 32'h112233AB, "ld_long");
        apb(0, 8'h3C, 32'h0); chk("unmapped", {31'h0, e}, 32'h1);
        apb(1, OFS_CCR, 32'h80E0); cmd(SZ_BYTE, OP_HALT);
        rc(OFS_STATUS, 32'h0, "halt_nop");
        apb(1, OFS_CCR, 32'hE0); cmd(SZ_BYTE, OP_HALT);
        rc(OFS_STATUS, 32'h1, "halt");
        chk("clock_stop", {31'h0, clock_stop}, 32'h1);
        irq_level <= 3'h3; repeat (6) @(posedge pclk);
        rc(OFS_STATUS, 32'h1, "masked");
        irq_level <= 3'h7; repeat (6) @(posedge pclk);
        rc(OFS_STATUS, 32'h4, "wake");
        chk("irq_take", {31'h0, irq_take}, 32'h1);
        print_verdict();
    end
endmodule
